// >>> common/dram_link_if.sv
`timescale 1ns/1ps
interface dram_link_if;
    dram_write_pkg::cmd_e  cmd;
    logic [1:0]            bg;
    logic [1:0]            bank;
    logic [1:0]            col;
    logic                  burst_chop_addr_pin;
    logic                  auto_pre;
    dram_write_pkg::mode_s mode;
    logic [3:0]            dq;
    logic                  dq_strobe;
    logic [3:0]            rdq;
    logic                  rdq_valid;

    modport ctrl (output cmd, bg, bank, col, burst_chop_addr_pin, auto_pre, mode, dq,
                  dq_strobe, input rdq, rdq_valid);
    modport dev  (input cmd, bg, bank, col, burst_chop_addr_pin, auto_pre, mode, dq,
                  dq_strobe, output rdq, rdq_valid);
endinterface : dram_link_if

// >>> common/dram_write_pkg.sv
`include "dram_write_regs.svh"
package dram_write_pkg;
    typedef enum logic [2:0] {
        CMD_NOP      = 3'h0,
        CMD_WRITE    = 3'h1,
        CMD_READ     = 3'h2,
        CMD_PRE_ALL  = 3'h3,
        CMD_MODE_SET = 3'h4
    } cmd_e;

    typedef struct packed {
        logic [4:0] lat;
        logic       msk_en;
        logic       crc_en;
        logic       long_pre;
        logic [1:0] burst;
    } mode_s;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_WLAT = 2'h1,
        ST_BEAT = 2'h2,
        ST_READ = 2'h3
    } ctrl_state_e;

    function automatic logic chop_four(input logic [1:0] burst, input logic pin);
        return (burst == `BURST_FIXED4) || (burst == `BURST_SEL && !pin);
    endfunction : chop_four
endpackage : dram_write_pkg

// >>> common/dram_write_regs.svh
`ifndef DRAM_WRITE_REGS_SVH
`define DRAM_WRITE_REGS_SVH
// Overview of operation
// - Eight beats: field 00, or 01 with pin high
// - Field 01 with pin low: chop to four
// - Field 10: always chop to four beats
// - Long preamble forbids write latency nine
// - Long preamble: no six-clock CRC write spacing
// - Recovery counts from edge after last beat
// - CRC plus mask selects longer recovery delays
// - Major violation needs reset; minor stays confined
// - Setup/hold violation corrupts only that write
// - Strobe timing violation corrupts only that write
// - Tolerance needs CRC and per-command select off
// - Offending strobe within six edges of latency
// - Reads accepted after an offending write
// - Same-group writes allowed after same-group spacing
// - Cross-group writes allowed after cross-group spacing
// - Precharge all restores correct later writes

// Burst field encodings and latency values
`define BURST_FIXED8 2'h0
`define BURST_SEL 2'h1
`define BURST_FIXED4 2'h2
`define LAT_BANNED_LONG_PRE 5'h09
`define LAT_RESET 5'h09

// Timing: times in ns, counts derived from the clock
`define CLK_PERIOD_NS 40
`define NS_TO_CYC(t) (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WR_REC_NS 15
`define WR_REC_CRC_MSK_NS 20
`define W2R_S_NS 3
`define W2R_S_CRC_MSK_NS 5
`define W2R_L_NS 8
`define W2R_L_CRC_MSK_NS 10
`define SAME_GROUP_SPACING 6
`define CROSS_GROUP_SPACING 4
`define CRC_SPACING_ONE_PRE 5
`define READ_LATENCY 11
`define CRC_BEAT 4'hF

// Controller software registers
`define A_CFG 4'h0
`define A_WDATA 4'h1
`define A_CMD 4'h2
`define A_STATUS 4'h3
`define A_RDATA 4'h4
`define CMD_WRITE_BIT 0
`define CMD_READ_BIT 1
`define CMD_PRE_BIT 2
`define CMD_AUTOPRE_BIT 3
`define CMD_SKIP_BIT 4
`define CMD_CHOP_BIT 5
`define CMD_BG_LSB 6
`define CMD_BANK_LSB 8
`define CMD_COL_LSB 10
`endif

// >>> design/dram_ctrl_end.sv
`timescale 1ns/1ps
`include "dram_write_regs.svh"
module dram_ctrl_end (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // Software port
    input  wire logic [3:0]  sw_addr,
    input  wire logic [31:0] sw_wdata,
    input  wire logic        sw_wr,
    input  wire logic        sw_rd,
    output logic      [31:0] sw_rdata,
    // Write data buffer ready toward software
    output logic             wbuf_ready,
    // Link
    dram_link_if.ctrl        link
);
    localparam int unsigned DEPTH = 2;

    dram_write_pkg::ctrl_state_e state_q;
    dram_write_pkg::mode_s       cfg_q;
    logic [31:0] fifo_q [DEPTH];
    logic        wptr_q;
    logic        rptr_q;
    logic [1:0]  cnt_q;
    logic        cfg_err_q;
    logic        refused_q;
    logic        mrs_pend_q;
    logic        cmd_pend_q;
    logic [11:0] cmd_q;
    logic [5:0]  since_wr_q;
    logic [5:0]  since_cmd_q;
    logic [1:0]  last_bg_q;
    logic [4:0]  lat_q;
    logic [3:0]  beat_q;
    logic [3:0]  total_q;
    logic [31:0] shift_q;
    logic [31:0] rdata_q;
    logic        rvalid_q;
    logic [3:0]  rbeat_q;
    logic        rchop_q;
    logic        skip_q;
    logic        push;
    logic        pop;
    logic        same_bg;
    logic        both_crc_msk;
    logic [5:0]  wr_spacing;
    logic [5:0]  w2r_need;
    logic [5:0]  rec_need;
    logic        go_write;
    logic        go_read;
    logic        go_pre;
    logic        cmd_chop;

    // CRC write spacing; the long preamble adds one clock so six is skipped
    function automatic logic [5:0] crc_spacing(input logic long_pre);
        logic [5:0] s;
        s = 6'(`CRC_SPACING_ONE_PRE);
        if (long_pre) begin
            s = s + 6'h01;
            if (s == 6'h06) begin
                s = 6'h07;
            end
        end
        return s;
    endfunction : crc_spacing

    assign wbuf_ready  = (cnt_q != 2'(DEPTH));
    assign push        = sw_wr && sw_addr == `A_WDATA && wbuf_ready;
    assign same_bg     = cmd_q[`CMD_BG_LSB +: 2] == last_bg_q;
    assign both_crc_msk = cfg_q.crc_en && cfg_q.msk_en;
    assign cmd_chop    = dram_write_pkg::chop_four(cfg_q.burst, cmd_q[`CMD_CHOP_BIT]);

    always_comb begin
        if (cfg_q.crc_en) begin
            wr_spacing = crc_spacing(cfg_q.long_pre);
        end else if (same_bg) begin
            wr_spacing = 6'(`SAME_GROUP_SPACING);
        end else begin
            wr_spacing = 6'(`CROSS_GROUP_SPACING);
        end
    end

    // Mask plus CRC selects the longer variants
    always_comb begin
        if (both_crc_msk) begin
            rec_need = 6'(`NS_TO_CYC(`WR_REC_CRC_MSK_NS));
            w2r_need = same_bg ? 6'(`NS_TO_CYC(`W2R_L_CRC_MSK_NS))
                               : 6'(`NS_TO_CYC(`W2R_S_CRC_MSK_NS));
        end else begin
            rec_need = 6'(`NS_TO_CYC(`WR_REC_NS));
            w2r_need = same_bg ? 6'(`NS_TO_CYC(`W2R_L_NS)) : 6'(`NS_TO_CYC(`W2R_S_NS));
        end
    end

    // Read and precharge delays count from the edge after the last beat; write spacing counts from the write command
    assign go_write = state_q == dram_write_pkg::ST_IDLE && cmd_pend_q && !mrs_pend_q
                      && cmd_q[`CMD_WRITE_BIT] && cnt_q != 2'h0 && since_cmd_q >= wr_spacing;
    assign go_read  = state_q == dram_write_pkg::ST_IDLE && cmd_pend_q && !mrs_pend_q
                      && cmd_q[`CMD_READ_BIT] && since_wr_q >= w2r_need;
    assign go_pre   = state_q == dram_write_pkg::ST_IDLE && cmd_pend_q && !mrs_pend_q
                      && cmd_q[`CMD_PRE_BIT] && since_wr_q >= rec_need;
    assign pop      = go_write;

    // Two-entry write data buffer; a stall here holds the write command back
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wptr_q <= 1'b0;
            rptr_q <= 1'b0;
            cnt_q  <= 2'h0;
        end else begin
            if (push) begin
                wptr_q <= ~wptr_q;
            end
            if (pop) begin
                rptr_q <= ~rptr_q;
            end
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge mclk) begin
        if (push) begin
            fifo_q[wptr_q] <= sw_wdata;
        end
    end

    // Configuration and command intake
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q      <= '{lat: `LAT_RESET, default: '0};
            cfg_err_q  <= 1'b0;
            mrs_pend_q <= 1'b0;
            cmd_pend_q <= 1'b0;
            cmd_q      <= 12'h000;
            refused_q  <= 1'b0;
        end else begin
            if (sw_wr && sw_addr == `A_CFG) begin
                // Rejected settings leave the old mode in force
                if (sw_wdata[2] && sw_wdata[9:5] == `LAT_BANNED_LONG_PRE) begin
                    cfg_err_q <= 1'b1;
                end else if (state_q != dram_write_pkg::ST_IDLE || cmd_pend_q) begin
                    refused_q <= 1'b1;
                end else begin
                    cfg_q      <= dram_write_pkg::mode_s'(sw_wdata[9:0]);
                    cfg_err_q  <= 1'b0;
                    mrs_pend_q <= 1'b1;
                end
            end else if (mrs_pend_q) begin
                mrs_pend_q <= 1'b0;
            end
            if (sw_wr && sw_addr == `A_CMD) begin
                if (cmd_pend_q) begin
                    refused_q <= 1'b1;
                end else begin
                    cmd_q      <= sw_wdata[11:0];
                    cmd_pend_q <= |sw_wdata[2:0];
                end
            end else if (go_write || go_read || go_pre) begin
                cmd_pend_q <= 1'b0;
            end
            if (sw_rd && sw_addr == `A_STATUS) begin
                refused_q <= 1'b0;
            end
        end
    end

    // Command, write beats and read collection
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q   <= dram_write_pkg::ST_IDLE;
            link.cmd  <= dram_write_pkg::CMD_NOP;
            link.bg   <= 2'h0;
            link.bank <= 2'h0;
            link.col  <= 2'h0;
            link.burst_chop_addr_pin <= 1'b0;
            link.auto_pre  <= 1'b0;
            link.mode      <= '0;
            link.dq        <= 4'h0;
            link.dq_strobe <= 1'b0;
            since_wr_q  <= 6'h3F;
            since_cmd_q <= 6'h3F;
            last_bg_q   <= 2'h0;
            lat_q   <= 5'h00;
            beat_q  <= 4'h0;
            total_q <= 4'h0;
            shift_q <= 32'h0000_0000;
            skip_q  <= 1'b0;
            rbeat_q <= 4'h0;
            rchop_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rvalid_q <= 1'b0;
        end else begin
            link.cmd <= dram_write_pkg::CMD_NOP;
            if (since_wr_q != 6'h3F) begin
                since_wr_q <= since_wr_q + 6'h01;
            end
            if (since_cmd_q != 6'h3F) begin
                since_cmd_q <= since_cmd_q + 6'h01;
            end
            if (sw_rd && sw_addr == `A_RDATA) begin
                rvalid_q <= 1'b0;
            end
            if (cmd_pend_q || mrs_pend_q) begin
                link.bg   <= cmd_q[`CMD_BG_LSB +: 2];
                link.bank <= cmd_q[`CMD_BANK_LSB +: 2];
                link.col  <= cmd_q[`CMD_COL_LSB +: 2];
                link.burst_chop_addr_pin <= cmd_q[`CMD_CHOP_BIT];
                link.auto_pre <= cmd_q[`CMD_AUTOPRE_BIT];
                link.mode     <= cfg_q;
            end
            case (state_q)
                dram_write_pkg::ST_IDLE: begin
                    if (mrs_pend_q) begin
                        link.cmd <= dram_write_pkg::CMD_MODE_SET;
                    end else if (go_write) begin
                        link.cmd    <= dram_write_pkg::CMD_WRITE;
                        since_cmd_q <= 6'h00;
                        last_bg_q   <= cmd_q[`CMD_BG_LSB +: 2];
                        lat_q   <= cfg_q.lat;
                        total_q <= (cmd_chop ? 4'h4 : 4'h8) + {3'h0, cfg_q.crc_en};
                        shift_q <= fifo_q[rptr_q];
                        skip_q  <= cmd_q[`CMD_SKIP_BIT];
                        state_q <= dram_write_pkg::ST_WLAT;
                    end else if (go_read) begin
                        link.cmd <= dram_write_pkg::CMD_READ;
                        rbeat_q  <= 4'h0;
                        rchop_q  <= cmd_chop;
                        rdata_q  <= 32'h0000_0000;
                        rvalid_q <= 1'b0;
                        state_q  <= dram_write_pkg::ST_READ;
                    end else if (go_pre) begin
                        link.cmd <= dram_write_pkg::CMD_PRE_ALL;
                    end
                end
                dram_write_pkg::ST_WLAT: begin
                    lat_q <= lat_q - 5'h01;
                    if (lat_q == 5'h01) begin
                        link.dq        <= shift_q[3:0];
                        link.dq_strobe <= !skip_q;
                        shift_q <= {4'h0, shift_q[31:4]};
                        beat_q  <= 4'h1;
                        state_q <= dram_write_pkg::ST_BEAT;
                    end
                end
                dram_write_pkg::ST_BEAT: begin
                    if (beat_q == total_q) begin
                        link.dq_strobe <= 1'b0;
                        since_wr_q <= 6'h00;
                        state_q    <= dram_write_pkg::ST_IDLE;
                    end else begin
                        link.dq        <= (cfg_q.crc_en && beat_q == total_q - 4'h1)
                                          ? `CRC_BEAT : shift_q[3:0];
                        link.dq_strobe <= 1'b1;
                        shift_q <= {4'h0, shift_q[31:4]};
                        beat_q  <= beat_q + 4'h1;
                    end
                end
                dram_write_pkg::ST_READ: begin
                    if (link.rdq_valid) begin
                        rdata_q <= rchop_q ? {16'h0000, link.rdq, rdata_q[15:4]}
                                           : {link.rdq, rdata_q[31:4]};
                        rbeat_q <= rbeat_q + 4'h1;
                        if (rbeat_q == (rchop_q ? 4'h3 : 4'h7)) begin
                            rvalid_q <= 1'b1;
                            state_q  <= dram_write_pkg::ST_IDLE;
                        end
                    end
                end
                default: state_q <= dram_write_pkg::ST_IDLE;
            endcase
        end
    end

    // Read data one cycle after the strobe
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sw_rdata <= 32'h0000_0000;
        end else if (sw_rd) begin
            case (sw_addr)
                `A_CFG:    sw_rdata <= {22'h000000, cfg_q};
                `A_STATUS: sw_rdata <= {26'h0000000, rvalid_q, refused_q, cfg_err_q,
                                        cnt_q == 2'h0, !wbuf_ready,
                                        state_q != dram_write_pkg::ST_IDLE || cmd_pend_q};
                `A_RDATA:  sw_rdata <= rdata_q;
                default:   sw_rdata <= 32'h0000_0000;
            endcase
        end else begin
            sw_rdata <= 32'h0000_0000;
        end
    end
endmodule : dram_ctrl_end

// >>> design/dram_device_end.sv
`timescale 1ns/1ps
`include "dram_write_regs.svh"
module dram_device_end (
    // Clock and reset
    input  wire logic  mclk,
    input  wire logic  rst_n,
    // Link
    dram_link_if.dev   link,
    // Status
    output logic       wr_done,
    output logic       tainted,
    output logic       fault
);
    dram_write_pkg::mode_s mode_reg_zero_q;
    logic [31:0] mem_q [64];
    logic [5:0]  idx_q;
    logic [4:0]  lat_q;
    logic [3:0]  beat_q;
    logic [3:0]  total_q;
    logic        wr_act_q;
    logic        viol_q;
    logic [31:0] word_q;
    logic [3:0]  rlat_q;
    logic [3:0]  rbeat_q;
    logic        rd_act_q;
    logic        rchop_q;
    logic [31:0] rword_q;
    logic        wr_chop;
    logic [3:0]  data_beats;

    // Fresh write's burst length, decided by the field and pin
    assign wr_chop = dram_write_pkg::chop_four(mode_reg_zero_q.burst,
                                               link.burst_chop_addr_pin);
    assign data_beats = total_q[0] ? total_q - 4'h1 : total_q;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg_zero_q <= '{lat: `LAT_RESET, default: '0};
        end else if (link.cmd == dram_write_pkg::CMD_MODE_SET) begin
            mode_reg_zero_q <= link.mode;
        end
    end

    // Write capture; CRC beat is taken but never checked
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wr_act_q <= 1'b0;
            lat_q    <= 5'h00;
            beat_q   <= 4'h0;
            total_q  <= 4'h0;
            idx_q    <= 6'h00;
            viol_q   <= 1'b0;
            word_q   <= 32'h0000_0000;
            wr_done  <= 1'b0;
        end else begin
            wr_done <= 1'b0;
            if (link.cmd == dram_write_pkg::CMD_WRITE && !wr_act_q) begin
                wr_act_q <= 1'b1;
                lat_q    <= mode_reg_zero_q.lat - 5'h01;
                beat_q   <= 4'h0;
                total_q  <= (wr_chop ? 4'h4 : 4'h8) + {3'h0, mode_reg_zero_q.crc_en};
                idx_q    <= {link.bg, link.bank, link.col};
                viol_q   <= 1'b0;
                word_q   <= 32'h0000_0000;
            end else if (wr_act_q && lat_q != 5'h00) begin
                lat_q <= lat_q - 5'h01;
            end else if (wr_act_q) begin
                if (beat_q < data_beats) begin
                    word_q <= {link.dq, word_q[31:4]};
                    // A missing strobe edge only spoils this word
                    if (!link.dq_strobe) begin
                        viol_q <= 1'b1;
                    end
                end
                beat_q <= beat_q + 4'h1;
                if (beat_q == total_q - 4'h1) begin
                    wr_act_q <= 1'b0;
                    wr_done  <= 1'b1;
                end
            end
        end
    end

    // Storage stays usable after a bad write; later writes go through
    always_ff @(posedge mclk) begin
        if (wr_done) begin
            mem_q[idx_q] <= (data_beats == 4'h4) ? {16'h0000, word_q[31:16]} : word_q;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tainted <= 1'b0;
            fault   <= 1'b0;
        end else begin
            // Precharge all returns to idle; later clean writes are correct
            if (link.cmd == dram_write_pkg::CMD_PRE_ALL) begin
                tainted <= 1'b0;
            end
            if (wr_done && viol_q) begin
                tainted <= 1'b1;
                // Outside the tolerated mode only a full reset recovers
                if (mode_reg_zero_q.crc_en || mode_reg_zero_q.burst == `BURST_SEL) begin
                    fault <= 1'b1;
                end
            end
        end
    end

    // Reads are served whatever the previous write did
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rd_act_q      <= 1'b0;
            rlat_q        <= 4'h0;
            rbeat_q       <= 4'h0;
            rchop_q       <= 1'b0;
            rword_q       <= 32'h0000_0000;
            link.rdq      <= 4'h0;
            link.rdq_valid <= 1'b0;
        end else begin
            link.rdq_valid <= 1'b0;
            if (link.cmd == dram_write_pkg::CMD_READ && !rd_act_q) begin
                rd_act_q <= 1'b1;
                rlat_q   <= 4'(`READ_LATENCY - 1);
                rbeat_q  <= 4'h0;
                rchop_q  <= wr_chop;
                rword_q  <= mem_q[{link.bg, link.bank, link.col}];
            end else if (rd_act_q && rlat_q != 4'h0) begin
                rlat_q <= rlat_q - 4'h1;
            end else if (rd_act_q) begin
                link.rdq       <= rword_q[3:0];
                link.rdq_valid <= 1'b1;
                rword_q        <= {4'h0, rword_q[31:4]};
                rbeat_q        <= rbeat_q + 4'h1;
                if (rbeat_q == (rchop_q ? 4'h3 : 4'h7)) begin
                    rd_act_q <= 1'b0;
                end
            end
        end
    end
endmodule : dram_device_end

// >>> verification/dram_write_path_checks_bench.sv
`timescale 1ns/1ps
`include "dram_write_regs.svh"
module dram_write_path_checks_bench;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic [3:0]  sw_addr = 4'h0;
    logic [31:0] sw_wdata = 32'h0;
    logic        sw_wr = 1'b0;
    logic        sw_rd = 1'b0;
    logic [31:0] sw_rdata;
    logic [31:0] d;
    logic        wbuf_ready;
    logic        wr_done;
    logic        tainted;
    logic        fault;
    int          fail_count = 0;
    int          compares = 0;
    always #20 mclk = ~mclk;
    dram_link_if link ();
    dram_ctrl_end dram_ctrl_end_inst (.mclk(mclk), .rst_n(rst_n), .sw_addr(sw_addr),
        .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
        .wbuf_ready(wbuf_ready), .link(link));
    dram_device_end dram_device_end_inst (.mclk(mclk), .rst_n(rst_n), .link(link),
        .wr_done(wr_done), .tainted(tainted), .fault(fault));
    dram_write_props props_inst (.mclk(mclk), .rst_n(rst_n), .cmd(link.cmd), .bg(link.bg),
        .burst_chop_addr_pin(link.burst_chop_addr_pin), .mode(link.mode),
        .dq_strobe(link.dq_strobe), .rdq_valid(link.rdq_valid), .wr_done(wr_done),
        .tainted(tainted), .fault(fault));
    task automatic end_of_test();
        if (fail_count == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge mclk);
        sw_addr  <= a;
        sw_wdata <= v;
        sw_wr    <= 1'b1;
        @(posedge mclk);
        sw_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge mclk);
        sw_addr <= a;
        sw_rd   <= 1'b1;
        @(posedge mclk);
        sw_rd <= 1'b0;
        #1 d = sw_rdata;
    endtask : rd
    // Polls status; a bounded wait so a stuck controller shows as a mismatch
    task automatic await(input logic [31:0] m, input logic [31:0] v);
        int n;
        for (n = 0; n < 300; n++) begin
            rd(`A_STATUS);
            if ((d & m) === v) break;
        end
        if (n == 300) fail_count++;
    endtask : await
    task automatic cfg(input logic [31:0] v);
        wr(`A_CFG, v);
        await(32'h1, 32'h0);
    endtask : cfg
    task automatic cmdw(input logic [31:0] c);
        int n;
        wr(`A_CMD, c | 32'h1);
        for (n = 0; n < 300 && wr_done !== 1'b1; n++) begin
            @(posedge mclk);
            #1;
        end
        if (n == 300) fail_count++;
        await(32'h1, 32'h0);
    endtask : cmdw
    task automatic rdback(input logic [31:0] c, input logic [31:0] v, input logic [31:0] m);
        wr(`A_CMD, c | 32'h2);
        await(32'h20, 32'h20);
        rd(`A_RDATA);
        chk(d & m, v & m);
    endtask : rdback
    initial begin
        logic [1:0]  b;
        logic [31:0] c;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        rd(`A_STATUS);
        chk(d, 32'h4);
        // Fixed eight, per-command eight, per-command chop, fixed chop
        for (int i = 0; i < 4; i++) begin
            b = (i == 0) ? 2'h0 : (i == 3) ? 2'h2 : 2'h1;
            c = {26'h0, i[0], 5'h0} | (i << 10);
            cfg(32'h120 | b);
            wr(`A_WDATA, 32'h8765_4321 + i);
            cmdw(c);
            rdback(c, 32'h8765_4321 + i, (b == 2'h2 || (b == 2'h1 && !i[0])) ? 32'hFFFF : 32'hFFFFFFFF);
        end
        wr(`A_CFG, 32'h124);
        rd(`A_STATUS);
        chk(d & 32'h8, 32'h8);
        rd(`A_CFG);
        chk(d, 32'h122);
        // Third push meets a full buffer and must be dropped
        cfg(32'h120);
        for (int i = 0; i < 3; i++) wr(`A_WDATA, 32'hA0 + i);
        rd(`A_STATUS);
        chk(d & 32'h6, 32'h2);
        chk({31'h0, wbuf_ready}, 32'h0);
        cmdw(32'h040);
        cmdw(32'h440);
        rdback(32'h040, 32'hA0, 32'hFFFFFFFF);
        rdback(32'h440, 32'hA1, 32'hFFFFFFFF);
        cfg(32'h15C);
        wr(`A_WDATA, 32'hB0);
        wr(`A_WDATA, 32'hB1);
        cmdw(32'h080);
        cmdw(32'h000);
        rdback(32'h080, 32'hB0, 32'hFFFFFFFF);
        rdback(32'h000, 32'hB1, 32'hFFFFFFFF);
        // Missing strobe on beat zero marks the write as damaged
        cfg(32'h120);
        wr(`A_WDATA, 32'h55);
        cmdw(32'h810);
        chk({31'h0, tainted}, 32'h1);
        chk({31'h0, fault}, 32'h0);
        rdback(32'h800, 32'h0, 32'h0);
        wr(`A_WDATA, 32'h66);
        cmdw(32'hC00);
        wr(`A_CMD, 32'h4);
        await(32'h1, 32'h0);
        chk({31'h0, tainted}, 32'h0);
        wr(`A_WDATA, 32'h77);
        cmdw(32'h800);
        rdback(32'h800, 32'h77, 32'hFFFFFFFF);
        cfg(32'h121);
        wr(`A_WDATA, 32'h88);
        cmdw(32'h030);
        chk({31'h0, fault}, 32'h1);
        @(posedge mclk) rst_n <= 1'b0;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        #1 chk({31'h0, fault}, 32'h0);
        end_of_test();
    end
    initial begin
        #800000;
        fail_count++;
        end_of_test();
    end
endmodule : dram_write_path_checks_bench

// >>> verification/dram_write_props.sv
`timescale 1ns/1ps
`include "dram_write_regs.svh"
module dram_write_props (
    // Clock and reset
    input wire logic              mclk,
    input wire logic              rst_n,
    // Link
    input dram_write_pkg::cmd_e   cmd,
    input wire logic [1:0]        bg,
    input wire logic              burst_chop_addr_pin,
    input dram_write_pkg::mode_s  mode,
    input wire logic              dq_strobe,
    input wire logic              rdq_valid,
    // Device status
    input wire logic              wr_done,
    input wire logic              tainted,
    input wire logic              fault
);
    localparam int W2R_CRC = `NS_TO_CYC(`W2R_L_CRC_MSK_NS);
    logic [5:0] since_q;
    logic [5:0] gap_q;
    logic [4:0] wcwl_q;
    logic [1:0] wb_q;
    logic [1:0] pbg_q;
    logic       wpin_q;
    logic       wcrc_q;
    wire        wr_c = cmd == dram_write_pkg::CMD_WRITE;
    // Counters saturate so a long idle never wraps into a false spacing
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            since_q <= 6'h3F;
            gap_q   <= 6'h3F;
            {wcwl_q, wb_q, wpin_q, wcrc_q, pbg_q} <= '0;
        end else begin
            since_q <= wr_c ? 6'h01 : since_q + {5'h0, since_q != 6'h3F};
            gap_q   <= dq_strobe ? 6'h00 : gap_q + {5'h0, gap_q != 6'h3F};
            if (wr_c) begin
                {wcwl_q, wb_q, wpin_q, wcrc_q, pbg_q} <=
                    {mode.lat, mode.burst, burst_chop_addr_pin, mode.crc_en, bg};
            end
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence burst_end; $fell(dq_strobe); endsequence
    sequence read_beats; rdq_valid [*4]; endsequence
    AST_BURST_EIGHT: assert property (burst_end and ##0 (wb_q == 2'h0 ||
        (wb_q == 2'h1 && wpin_q)) |-> since_q == wcwl_q + 6'h08 + wcrc_q) else $error("bad eight");
    AST_CHOP_SEL: assert property (burst_end and ##0 (wb_q == 2'h1 && !wpin_q)
        |-> since_q == wcwl_q + 6'h04 + wcrc_q) else $error("bad sel chop");
    AST_CHOP_FIXED: assert property (burst_end and ##0 wb_q == 2'h2
        |-> since_q == wcwl_q + 6'h04 + wcrc_q) else $error("bad fixed chop");
    AST_LONG_PRE_LAT: assert property (mode.long_pre |-> mode.lat != 5'h09)
        else $error("lat 9 with long preamble");
    AST_CRC_SPACING: assert property (wr_c && mode.crc_en && mode.long_pre
        |-> since_q != 6'h06 && since_q >= 6'h05) else $error("bad crc spacing");
    AST_DONE_AFTER_LAST: assert property (burst_end |-> wr_done ##1 !wr_done)
        else $error("done not after last beat");
    AST_READ_GAP: assert property (cmd == dram_write_pkg::CMD_READ |-> gap_q >= 6'h01)
        else $error("read too soon after write");
    AST_READ_GAP_CRC: assert property (cmd == dram_write_pkg::CMD_READ && mode.crc_en &&
        mode.msk_en |-> gap_q >= W2R_CRC) else $error("crc mask read too soon");
    AST_FAULT_STICKY: assert property (fault |=> fault)
        else $error("fault dropped");
    AST_READ_ANSWERED: assert property (cmd == dram_write_pkg::CMD_READ |-> ##12 read_beats)
        else $error("read not answered");
    AST_SAME_GROUP: assert property (wr_c && !mode.crc_en && bg == pbg_q
        |-> since_q >= 6'h06) else $error("same group spacing");
    AST_CROSS_GROUP: assert property (wr_c && !mode.crc_en && bg != pbg_q
        |-> since_q >= 6'h04) else $error("cross group spacing");
    AST_PRE_CLEARS: assert property (cmd == dram_write_pkg::CMD_PRE_ALL |=> !tainted)
        else $error("taint kept after precharge");
endmodule : dram_write_props
